// File: design/acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_FB 8'h04
`define ACS_OFF_INS_CH 8'h08
`define ACS_OFF_INS_SEQ 8'h0C
`define ACS_OFF_TMO 8'h10
`define ACS_OFF_TIMING 8'h18
`define ACS_OFF_SQ_FIRST 8'h20
`define ACS_OFF_SQ_LAST 8'h34
`define ACS_OFF_IRQ_STS 8'h40
`define ACS_OFF_IRQ_MSK 8'h44
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ACS_START_BIT 0
`define ACS_EOC_BIT 1
`define ACS_SWACT_BIT 2
`define ACS_SWCH_LSB 8
`define ACS_SWSEL_BIT 4
`define ACS_INS_SEQ_EN_BIT 16
`define ACS_FIELD_MASK 32'h0FFF0FFF
////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ACS_SQ01_RST 32'h003C0FFF
`define ACS_SQ23_RST 32'h0FFF0800
`define ACS_SQ45_RST 32'h00000000
`define ACS_SQ67_RST 32'h00000FFF
`define ACS_SQ89_RST 32'h0FFF0000
`define ACS_SQ1011_RST 32'h00000000
`define ACS_SAMPLE_RST 3'h4
`define ACS_TMO_RST 16'h0000
////////////////////////////////////////////////////////////////////////////////
// Timing in converter clock cycles, and the insertion queue limit
`define ACS_SWITCH_CYC 6'h01
`define ACS_SAMPLE_BASE 6'h04
`define ACS_CONV_CYC 6'h04
`define ACS_HOLD_CYC 6'h09
`define ACS_INS_MAX 6'h3F
`endif

// File: design/acs_conv_timer.v
`timescale 1ns/100ps
module acs_conv_timer (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire start,
  input wire [2:0] sample_set,
  output wire busy,
  output wire sampling,
  output wire result_strobe,
  output wire slot_done
);
`include "acs_consts.vh"
  reg [5:0] cnt;
  reg [5:0] samp_len;
  wire [5:0] conv_len;
  wire [5:0] period;
  // Sampling length is 2*setting+4, so setting 4 gives 12 cycles
  assign conv_len = `ACS_SWITCH_CYC + samp_len + `ACS_CONV_CYC;
  assign period = conv_len + `ACS_HOLD_CYC;
  assign busy = (cnt != 6'h00);
  assign sampling = (cnt > `ACS_SWITCH_CYC) && (cnt <= `ACS_SWITCH_CYC + samp_len);
  assign result_strobe = (cnt == conv_len);
  assign slot_done = (cnt == period);
  always @(posedge ref_clk) begin
    if (!resetn) begin
      cnt <= 6'h00;
      samp_len <= 6'h0C;
    end else if (ce) begin
      if (start) begin
        cnt <= 6'h01;
        samp_len <= {2'b00, sample_set, 1'b0} + `ACS_SAMPLE_BASE;
      end else if (slot_done) begin
        cnt <= 6'h00;
      end else if (busy) begin
        cnt <= cnt + 6'h01;
      end
    end
  end
endmodule

// File: design/acs_slot_scan.v
`timescale 1ns/100ps
module acs_slot_scan #(
  parameter SLOTS = 144
) (
  input wire [SLOTS-1:0] masks,
  input wire [7:0] cur_slot,
  output reg found,
  output reg [7:0] next_slot,
  output reg [3:0] next_chan
);
  wire [SLOTS-1:0] slot_bit;
  integer i;
  integer idx;
  integer rem;
  genvar s;
  // Slot 12m+j is mask m, bit 11-j: masks scanned MSB first
  generate
    for (s = 0; s < SLOTS; s = s + 1) begin : g_order
      assign slot_bit[s] = masks[12 * (s / 12) + 11 - (s % 12)];
    end
  endgenerate
  // Nearest set slot after the current one, wrapping past the end
  always @* begin
    found = 1'b0;
    next_slot = 8'h00;
    next_chan = 4'h0;
    idx = 0;
    rem = 0;
    for (i = SLOTS; i >= 1; i = i - 1) begin
      idx = cur_slot + i;
      if (idx >= SLOTS) idx = idx - SLOTS;
      if (idx >= SLOTS) idx = idx - SLOTS;
      if (slot_bit[idx]) begin
        found = 1'b1;
        next_slot = idx[7:0];
        rem = idx % 12;
        next_chan = 4'hB - rem[3:0];
      end
    end
  end
endmodule

// File: design/acs_top.v
`timescale 1ns/100ps
module acs_top (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire single_channel_insertion,
  input wire sequence_insertion,
  input wire debug_suspend,
  input wire [9:0] adc_data,
  output reg [3:0] mux_channel,
  output wire adc_sample,
  output reg [9:0] result_data,
  output reg [3:0] result_channel,
  output reg result_valid,
  output wire irq
);
`include "acs_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Registers and state
  reg [31:0] sequence_mask [0:5];
  reg [3:0] insert_channel_select;
  reg [11:0] insert_sequence_mask;
  reg xseq_en;
  reg [15:0] software_timeout_limit;
  reg [2:0] sample_set;
  reg software_control_select;
  reg [3:0] sw_chan;
  reg eoc;
  reg sw_auto;
  reg [2:0] sw_src;
  reg [15:0] tmo_cnt;
  reg [1:0] irq_sts;
  reg [1:0] irq_msk;
  reg [7:0] cur_slot;
  reg [5:0] ins_cnt;
  reg xseq_pend;
  reg xseq_active;
  reg [3:0] xseq_pos;
  reg conv_sw;
  reg [2:0] sync_single;
  reg [2:0] sync_seq;
  reg [1:0] sync_dbg;
  wire [143:0] masks;
  wire scan_found;
  wire [7:0] scan_slot;
  wire [3:0] scan_chan;
  wire t_busy;
  wire t_result;
  wire t_done;
  reg t_start;
  reg [3:0] pick_chan;
  reg xseq_hit;
  reg [3:0] xseq_next;
  integer i;
  genvar k;
////////////////////////////////////////////////////////////////////////////////
// Bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ok = wb_req & wb_we_i & (wb_sel_i == 4'hF);
  wire rd_req = wb_req & ~wb_we_i;
  wire is_sq = (wb_adr_i >= `ACS_OFF_SQ_FIRST) && (wb_adr_i <= `ACS_OFF_SQ_LAST)
               && (wb_adr_i[1:0] == 2'b00);
  wire [7:0] sq_off = wb_adr_i - `ACS_OFF_SQ_FIRST;
  wire [2:0] sq_idx = sq_off[4:2];
  wire wr_sq = wr_ok & is_sq;
  wire wr_ctrl = wr_ok & (wb_adr_i == `ACS_OFF_CTRL);
  wire wr_xseq = wr_ok & (wb_adr_i == `ACS_OFF_INS_SEQ);
  wire rd_ctrl = rd_req & (wb_adr_i == `ACS_OFF_CTRL);
  wire dat_lo_zero = (wb_dat_i[11:0] == 12'h000);
  wire dat_hi_zero = (wb_dat_i[27:16] == 12'h000);
////////////////////////////////////////////////////////////////////////////////
// Mode and events
  wire dbg_s = sync_dbg[1];
  wire sw_active = software_control_select | sw_auto | dbg_s;
  wire single_rise = sync_single[1] & ~sync_single[2];
  wire seq_rise = sync_seq[1] & ~sync_seq[2];
  // A limit lowered below the running count still ends the mode
  wire tmo_hit = (software_timeout_limit != 16'h0000) && (tmo_cnt >= software_timeout_limit);
  wire free = ~t_busy | t_done;
  wire start_req = wr_ctrl & wb_dat_i[`ACS_START_BIT];
  wire sw_go = sw_active & free & start_req & ~eoc;
  wire ins_take = ~sw_active & free & (ins_cnt != 6'h00);
  wire xseq_step = ~sw_active & free & ~ins_take & xseq_active & xseq_hit;
  wire xseq_end = ~sw_active & free & ~ins_take & xseq_active & ~xseq_hit;
  wire xseq_begin = ~sw_active & free & ~ins_take & ~xseq_active & xseq_pend & xseq_hit;
  // Scan resumes in the slot that ends the exception sequence, keeping the slot rhythm
  wire seq_take = ~sw_active & free & ~ins_take & ~(xseq_active & xseq_hit) & ~xseq_begin
                  & scan_found;
  wire eoc_set = t_result & conv_sw;
  assign irq = |(irq_sts & irq_msk);

  generate
    for (k = 0; k < 6; k = k + 1) begin : g_masks
      assign masks[24*k+11:24*k] = sequence_mask[k][11:0];
      assign masks[24*k+23:24*k+12] = sequence_mask[k][27:16];
    end
  endgenerate

  acs_slot_scan #(
    .SLOTS(144)
  ) u_scan (
    .masks(masks),
    .cur_slot(cur_slot),
    .found(scan_found),
    .next_slot(scan_slot),
    .next_chan(scan_chan)
  );

  acs_conv_timer u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .start(t_start),
    .sample_set(sample_set),
    .busy(t_busy),
    .sampling(adc_sample),
    .result_strobe(t_result),
    .slot_done(t_done)
  );

  // Highest exception bit below the last one converted, MSB first
  always @* begin
    xseq_hit = 1'b0;
    xseq_next = 4'h0;
    for (i = 0; i < 12; i = i + 1) begin
      if (insert_sequence_mask[i] && (!xseq_active || i < xseq_pos)) begin
        xseq_hit = 1'b1;
        xseq_next = i[3:0];
      end
    end
  end

  // Channel choice: queued single, exception step, normal scan, software
  always @* begin
    t_start = 1'b0;
    pick_chan = mux_channel;
    if (sw_go) begin
      t_start = 1'b1;
      // Channel comes with the start write itself, not the stale register
      pick_chan = wb_dat_i[`ACS_SWCH_LSB+3:`ACS_SWCH_LSB];
    end else if (ins_take) begin
      t_start = 1'b1;
      pick_chan = insert_channel_select;
    end else if (xseq_step | xseq_begin) begin
      t_start = 1'b1;
      pick_chan = xseq_next;
    end else if (seq_take) begin
      t_start = 1'b1;
      pick_chan = scan_chan;
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Synchronisers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sync_single <= 3'h0;
      sync_seq <= 3'h0;
      sync_dbg <= 2'h0;
    end else if (ce) begin
      sync_single <= {sync_single[1:0], single_channel_insertion};
      sync_seq <= {sync_seq[1:0], sequence_insertion};
      sync_dbg <= {sync_dbg[0], debug_suspend};
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Register writes and software mode
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sequence_mask[0] <= `ACS_SQ01_RST;
      sequence_mask[1] <= `ACS_SQ23_RST;
      sequence_mask[2] <= `ACS_SQ45_RST;
      sequence_mask[3] <= `ACS_SQ67_RST;
      sequence_mask[4] <= `ACS_SQ89_RST;
      sequence_mask[5] <= `ACS_SQ1011_RST;
      insert_channel_select <= 4'h0;
      insert_sequence_mask <= 12'h000;
      xseq_en <= 1'b0;
      software_timeout_limit <= `ACS_TMO_RST;
      sample_set <= `ACS_SAMPLE_RST;
      software_control_select <= 1'b0;
      sw_chan <= 4'h0;
      sw_auto <= 1'b0;
      sw_src <= 3'h0;
      tmo_cnt <= 16'h0000;
      irq_msk <= 2'h0;
    end else if (ce) begin
      if (wr_sq)
        sequence_mask[sq_idx] <= wb_dat_i & `ACS_FIELD_MASK;
      if (wr_ok && wb_adr_i == `ACS_OFF_INS_CH)
        insert_channel_select <= wb_dat_i[3:0];
      if (wr_xseq) begin
        insert_sequence_mask <= wb_dat_i[11:0];
        xseq_en <= wb_dat_i[`ACS_INS_SEQ_EN_BIT];
      end
      if (wr_ok && wb_adr_i == `ACS_OFF_TMO)
        software_timeout_limit <= wb_dat_i[15:0];
      if (wr_ok && wb_adr_i == `ACS_OFF_IRQ_MSK)
        irq_msk <= wb_dat_i[1:0];
      if (wr_ctrl)
        sw_chan <= wb_dat_i[`ACS_SWCH_LSB+3:`ACS_SWCH_LSB];
      if (wr_ok && wb_adr_i == `ACS_OFF_TIMING) begin
        sample_set <= wb_dat_i[2:0];
        software_control_select <= wb_dat_i[`ACS_SWSEL_BIT];
      end
      // Trigger register rewritten with no empty mask field ends automatic entry
      if (sw_auto && wr_sq && sw_src == sq_idx && !(dat_lo_zero && dat_hi_zero))
        sw_auto <= 1'b0;
      if (sw_auto && wr_xseq && sw_src == 3'h6 && !dat_lo_zero)
        sw_auto <= 1'b0;
      if (wr_sq && (dat_lo_zero || dat_hi_zero)) begin
        sw_auto <= 1'b1;
        sw_src <= sq_idx;
      end
      if (wr_xseq && wb_dat_i[`ACS_INS_SEQ_EN_BIT] && dat_lo_zero) begin
        sw_auto <= 1'b1;
        sw_src <= 3'h6;
      end
      // Timeout is held off while debug suspend forces the mode
      if (!sw_active || dbg_s) begin
        tmo_cnt <= 16'h0000;
      end else if (tmo_hit) begin
        tmo_cnt <= 16'h0000;
        sw_auto <= 1'b0;
        software_control_select <= 1'b0;
      end else begin
        tmo_cnt <= tmo_cnt + 16'h0001;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Sequencing
  always @(posedge ref_clk) begin
    if (!resetn) begin
      cur_slot <= 8'h8F;
      ins_cnt <= 6'h00;
      xseq_pend <= 1'b0;
      xseq_active <= 1'b0;
      xseq_pos <= 4'hC;
      conv_sw <= 1'b0;
      mux_channel <= 4'h0;
    end else if (ce) begin
      if (t_start) begin
        mux_channel <= pick_chan;
        conv_sw <= sw_go;
      end
      // Hardware events are dropped while software mode holds
      if (single_rise && !sw_active && ins_cnt != `ACS_INS_MAX && !ins_take)
        ins_cnt <= ins_cnt + 6'h01;
      else if (ins_take && !(single_rise && !sw_active))
        ins_cnt <= ins_cnt - 6'h01;
      if (seq_rise && !sw_active && xseq_en)
        xseq_pend <= 1'b1;
      else if (xseq_begin || (xseq_pend && !xseq_active && !xseq_hit))
        xseq_pend <= 1'b0;
      if (xseq_begin)
        xseq_active <= 1'b1;
      else if (xseq_end)
        xseq_active <= 1'b0;
      if (xseq_step || xseq_begin)
        xseq_pos <= xseq_next;
      else if (xseq_end)
        xseq_pos <= 4'hC;
      if (seq_take)
        cur_slot <= scan_slot;
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Results, flags and interrupts
  always @(posedge ref_clk) begin
    if (!resetn) begin
      result_data <= 10'h000;
      result_channel <= 4'h0;
      result_valid <= 1'b0;
      eoc <= 1'b0;
      irq_sts <= 2'h0;
    end else if (ce) begin
      result_valid <= t_result;
      if (t_result) begin
        result_data <= adc_data;
        result_channel <= mux_channel;
      end
      // Completion beats a read clear in the same cycle
      if (eoc_set)
        eoc <= 1'b1;
      else if (rd_ctrl)
        eoc <= 1'b0;
      irq_sts[0] <= xseq_end |
        (irq_sts[0] & ~(wr_ok && wb_adr_i == `ACS_OFF_IRQ_STS && wb_dat_i[0]));
      irq_sts[1] <= eoc_set |
        (irq_sts[1] & ~(wr_ok && wb_adr_i == `ACS_OFF_IRQ_STS && wb_dat_i[1]));
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Wishbone answer
  always @(posedge ref_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (rd_req) begin
        wb_dat_o <= 32'h00000000;
        if (is_sq) begin
          wb_dat_o <= sequence_mask[sq_idx];
        end else begin
          case (wb_adr_i)
            `ACS_OFF_CTRL: wb_dat_o <= {20'h00000, sw_chan, 5'h00, sw_active,
                                        eoc, conv_sw & t_busy};
            `ACS_OFF_FB: wb_dat_o <= {16'h0000, ins_cnt, xseq_active, sw_active, cur_slot};
            `ACS_OFF_INS_CH: wb_dat_o <= {28'h0000000, insert_channel_select};
            `ACS_OFF_INS_SEQ: wb_dat_o <= {15'h0000, xseq_en, 4'h0, insert_sequence_mask};
            `ACS_OFF_TMO: wb_dat_o <= {16'h0000, software_timeout_limit};
            `ACS_OFF_TIMING: wb_dat_o <= {27'h0000000, software_control_select, 1'b0,
                                          sample_set};
            `ACS_OFF_IRQ_STS: wb_dat_o <= {30'h00000000, irq_sts};
            `ACS_OFF_IRQ_MSK: wb_dat_o <= {30'h00000000, irq_msk};
            default: wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule

// File: bench/acs_adc_model.sv
`timescale 1ns/100ps
module acs_adc_model (
  input wire ref_clk,
  input wire [3:0] mux_channel,
  input wire adc_sample,
  output reg [9:0] adc_data
);
  reg [3:0] hold = 4'h0;
  initial adc_data = 10'h000;
  // Result stays valid a short while after sampling, then the lines wander
  always @(posedge ref_clk) begin
    if (adc_sample) begin
      hold <= 4'hA;
      adc_data <= {mux_channel, ~mux_channel, 2'b10};
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else begin
      adc_data <= ~adc_data;
    end
  end
endmodule

// File: bench/acs_top_properties.sv
`timescale 1ns/100ps
module acs_checker (
  input wire ref_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [3:0] mux_channel,
  input wire adc_sample,
  input wire [3:0] result_channel,
  input wire result_valid
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  sample_len_a: assert property ($rose(adc_sample) |->
    adc_sample [*8] ##1 adc_sample [*4] ##1 !adc_sample)
    else $error("sampling window not twelve cycles");
  sample_gap_a: assert property ($fell(adc_sample) |-> !adc_sample [*8])
    else $error("sampling restarted too early");
  result_lat_a: assert property ($rose(adc_sample) |-> ##[15:16] result_valid)
    else $error("result not on time");
  result_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  mux_hold_a: assert property (adc_sample |-> $stable(mux_channel))
    else $error("channel moved while sampling");
  result_chan_a: assert property (result_valid |-> result_channel == $past(mux_channel))
    else $error("result tagged with wrong channel");
  cover property ($rose(result_valid));
  cover property ($fell(adc_sample) ##8 !adc_sample);
  cover property (wb_ack_o);
endmodule
bind acs_top acs_checker u_acs_checker (.ref_clk(ref_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mux_channel(mux_channel),
  .adc_sample(adc_sample), .result_channel(result_channel), .result_valid(result_valid));

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg ce = 1'b1;
  reg debug_suspend = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  reg wb_we_i = 1'b0;
  reg [3:0] wb_sel_i = 4'hF;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg single_channel_insertion = 1'b0;
  reg sequence_insertion = 1'b0;
  wire [31:0] wb_dat_o;
  wire [9:0] adc_data;
  wire [9:0] result_data;
  wire [3:0] mux_channel;
  wire [3:0] result_channel;
  wire wb_ack_o;
  wire adc_sample;
  wire result_valid;
  wire irq;
  integer errors = 0;
  integer cmp_count = 0;
  integer cyc_n = 0;
  integer slot = 0;
  integer last_t = -1;
  integer sw_cnt = 0;
  integer ins_q[$];
  integer i;
  integer ch;
  integer exp_ch;
  reg swm = 1'b0;
  reg [31:0] rd;
  reg [31:0] d;
  reg [11:0] r12;
  reg [11:0] m [0:11];
  reg [31:0] rst [0:5] = '{32'h003C0FFF, 32'h0FFF0800, 32'h0, 32'h00000FFF, 32'h0FFF0000, 32'h0};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc_n <= cyc_n + 1;

  acs_top u_acs_top (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .single_channel_insertion(single_channel_insertion),
    .sequence_insertion(sequence_insertion), .debug_suspend(debug_suspend),
    .adc_data(adc_data), .mux_channel(mux_channel), .adc_sample(adc_sample),
    .result_data(result_data), .result_channel(result_channel),
    .result_valid(result_valid), .irq(irq));
  acs_adc_model u_acs_adc_model (.ref_clk(ref_clk), .mux_channel(mux_channel),
    .adc_sample(adc_sample), .adc_data(adc_data));
  //////////////////////////////////////////////////
  task chk(input string name, input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task conclude;
    begin
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  function [9:0] conv_val(input [3:0] c);
    conv_val = {c, ~c, 2'b10};
  endfunction

  // Next set bit of the scan, first mask to last, high bit to low, with wrap
  function integer scan_next();
    integer k;
    integer b;
    begin
      scan_next = -1;
      for (k = 0; k < 144 && scan_next < 0; k = k + 1) begin
        b = 11 - slot % 12;
        if (m[slot / 12][b]) scan_next = b;
        slot = (slot + 1) % 144;
      end
    end
  endfunction

  task bus(input [7:0] a, input w, input [31:0] v, input [3:0] s);
    integer t;
    begin
      @(posedge ref_clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= v;
      wb_sel_i <= s;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      t = 0;
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1 && t < 50) begin
        t = t + 1;
        @(posedge ref_clk);
      end
      chk("ack_wait", t >= 50, 0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask

  task wait_res;
    integer t;
    begin
      t = 0;
      @(posedge ref_clk);
      while (result_valid !== 1'b1 && t < 400) begin
        t = t + 1;
        @(posedge ref_clk);
      end
      chk("res_wait", t >= 400, 0);
    end
  endtask

  task pulse(input s, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        if (s) sequence_insertion <= 1'b1;
        else single_channel_insertion <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sequence_insertion <= 1'b0;
        single_channel_insertion <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
    end
  endtask

  // Result stream against the bench scan model and pending insertions
  always @(negedge ref_clk) begin
    if (resetn && result_valid === 1'b1) begin
      if (swm) begin
        sw_cnt = sw_cnt + 1;
      end else begin
        if (ins_q.size() > 0) exp_ch = ins_q.pop_front();
        else exp_ch = scan_next();
        chk("channel", result_channel, exp_ch);
        chk("data", result_data, conv_val(exp_ch[3:0]));
        if (last_t >= 0) chk("period", cyc_n - last_t, 26);
        last_t = cyc_n;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    chk("watchdog", 1, 0);
    conclude;
  end
  //////////////////////////////////////////////////
  initial begin
    i = $urandom(32'h0077CF71);
    for (i = 0; i < 6; i = i + 1) begin
      m[2 * i] = rst[i][11:0];
      m[2 * i + 1] = rst[i][27:16];
    end
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      bus(8'(32 + 4 * i), 1'b0, 32'h0, 4'hF);
      chk("seq_reset", rd, rst[i]);
    end
    d = $urandom;
    d[11:0] = 12'($urandom % 4095 + 1);
    d[27:16] = 12'($urandom % 4095 + 1);
    bus(8'h34, 1'b1, d, 4'hF);
    m[10] = d[11:0];
    m[11] = d[27:16];
    bus(8'h34, 1'b0, 32'h0, 4'hF);
    chk("seq_rw", rd, d & 32'h0FFF0FFF);
    bus(8'h30, 1'b1, 32'h0, 4'h1);
    bus(8'h30, 1'b0, 32'h0, 4'hF);
    chk("byte_write", rd, rst[4]);
    bus(8'h3C, 1'b0, 32'h0, 4'hF);
    chk("unmapped", rd, 32'h0);
    ch = $urandom % 12;
    bus(8'h08, 1'b1, ch, 4'hF);
    wait_res;
    for (i = 0; i < 3; i = i + 1) ins_q.push_back(ch);
    pulse(1'b0, 3);
    repeat (3) wait_res;
    r12 = 12'($urandom % 4095 + 1);
    bus(8'h0C, 1'b1, {15'h0, 1'b1, 4'h0, r12}, 4'hF);
    wait_res;
    for (i = 11; i >= 0; i = i - 1) if (r12[i]) ins_q.push_back(i);
    pulse(1'b1, 1);
    for (i = 0; i < 1000 && ins_q.size() > 0; i = i + 1) @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    chk("irq_masked", irq, 1'b0);
    bus(8'h40, 1'b0, 32'h0, 4'hF);
    chk("irq_status", rd[0], 1'b1);
    bus(8'h44, 1'b1, 32'h1, 4'hF);
    @(posedge ref_clk);
    chk("irq_on", irq, 1'b1);
    bus(8'h40, 1'b1, 32'h1, 4'hF);
    @(posedge ref_clk);
    chk("irq_clear", irq, 1'b0);
    repeat (70) wait_res;
    bus(8'h18, 1'b1, 32'h14, 4'hF);
    repeat (30) @(posedge ref_clk);
    swm = 1'b1;
    pulse(1'b0, 1);
    pulse(1'b1, 1);
    repeat (60) @(posedge ref_clk);
    chk("sw_idle", sw_cnt, 0);
    ch = $urandom % 12;
    bus(8'h00, 1'b1, (ch << 8) | 1, 4'hF);
    wait_res;
    chk("sw_chan", result_channel, ch);
    chk("sw_data", result_data, conv_val(ch[3:0]));
    bus(8'h00, 1'b0, 32'h0, 4'hF);
    chk("eoc_set", rd[1], 1'b1);
    bus(8'h00, 1'b0, 32'h0, 4'hF);
    chk("eoc_clear", rd[1], 1'b0);
    chk("software_control_select", rd[2], 1'b1);
    bus(8'h10, 1'b1, 32'h5, 4'hF);
    bus(8'h00, 1'b0, 32'h0, 4'hF);
    chk("sw_timeout", rd[2], 1'b0);
    conclude;
  end
endmodule
